// file: rtl/rtcssp_regs.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial RTC port
// Assumes: pclk at 25 MHz
// Notes: Included by the package and both ends
`ifndef RTCSSP_REGS_SVH
`define RTCSSP_REGS_SVH

// Two-wire slave address byte, direction bit clear
`define RTCSSP_SLAVE_ADDR 8'hd0
`define RTCSSP_NREGS 8'h14
`define RTCSSP_NTIME 5'h08
`define RTCSSP_LAST_REG 5'h13

// Device register offsets
`define RTCSSP_OFS_FRAC 5'h00
`define RTCSSP_OFS_SEC 5'h01
`define RTCSSP_OFS_MIN 5'h02
`define RTCSSP_OFS_HOUR 5'h03
`define RTCSSP_OFS_WDAY 5'h04
`define RTCSSP_OFS_MDAY 5'h05
`define RTCSSP_OFS_MON 5'h06
`define RTCSSP_OFS_YEAR 5'h07
`define RTCSSP_OFS_CTRL 5'h08
`define RTCSSP_OFS_LFO 5'h09
`define RTCSSP_OFS_FLAGS 5'h0f
`define RTCSSP_OFS_RSV_LO 5'h10
`define RTCSSP_OFS_RSV_HI 5'h12

// Field positions
`define RTCSSP_BIT_HALT 7
`define RTCSSP_BIT_CTE 7
`define RTCSSP_BIT_CENT 6
`define RTCSSP_BIT_LFOE 7

// Reset values
`define RTCSSP_RST_REG 8'h00
`define RTCSSP_RST_LFO 8'h80
`define RTCSSP_RST_MDAY 8'h01

// Timing
`define RTCSSP_PCLK_HZ 25000000
`define RTCSSP_OSC_HZ 32768
`define RTCSSP_OSC_DIV (`RTCSSP_PCLK_HZ / `RTCSSP_OSC_HZ)
`define RTCSSP_OSC_PER_HUND ((`RTCSSP_OSC_HZ + 99) / 100)
`define RTCSSP_SCL_HZ 100000
`define RTCSSP_SCL_QTR (`RTCSSP_PCLK_HZ / (4 * `RTCSSP_SCL_HZ))

// Controller register offsets and command bits
`define RTCSSP_HOFS_CMD 8'h00
`define RTCSSP_HOFS_TXD 8'h04
`define RTCSSP_HOFS_RXD 8'h08
`define RTCSSP_HOFS_STAT 8'h0c
`define RTCSSP_CMD_START 0
`define RTCSSP_CMD_STOP 1
`define RTCSSP_CMD_WRITE 2
`define RTCSSP_CMD_READ 3
`define RTCSSP_CMD_NACK 4

`endif

// file: rtl/rtcssp_pkg.sv
// Purpose: Types of the serial RTC port
// Assumes: rtcssp_regs.svh holds the numbers
// Notes: All module state is one packed struct
`include "rtcssp_regs.svh"
package rtcssp_pkg;
  typedef enum logic [5:0] {
    DEV_IDLE = 6'h01,
    DEV_RX = 6'h02,
    DEV_ACK = 6'h04,
    DEV_TX = 6'h08,
    DEV_ACKR = 6'h10,
    DEV_IGN = 6'h20
  } rtcssp_dev_st_t;

  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_START = 4'h2,
    HST_STOP = 4'h4,
    HST_BIT = 4'h8
  } rtcssp_hst_st_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    rtcssp_dev_st_t st;
    logic [1:0] kind;
    logic rw;
    logic got;
    logic sda_oe;
    logic [2:0] bcnt;
    logic [7:0] sh;
    logic [4:0] ptr;
    logic [19:0][7:0] ur;
    logic [7:0][7:0] tm;
    logic [9:0] odiv;
    logic [8:0] hdiv;
    logic frz;
  } rtcssp_dev_s_t;

  typedef struct packed {
    logic [1:0] sda_s;
    rtcssp_hst_st_t st;
    logic [5:0] qcnt;
    logic [1:0] q;
    logic [3:0] bi;
    logic [8:0] sh;
    logic [7:0] txd;
    logic [7:0] rxd;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtcssp_hst_s_t;
endpackage

// file: rtl/rtcssp_if.sv
// Purpose: Two-wire link between controller and RTC port
// Assumes: Open-drain lines with pull-ups
// Notes: Line levels are resolved here from the enables
`timescale 1ns/1ps
interface rtcssp_if;
  logic scl_o;
  logic scl_oe;
  logic hsda_o;
  logic hsda_oe;
  logic dsda_o;
  logic dsda_oe;
  wire scl;
  wire sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (hsda_oe ? hsda_o : 1'b1) & (dsda_oe ? dsda_o : 1'b1);
  modport host (output scl_o, output scl_oe, output hsda_o, output hsda_oe, input scl, input sda);
  modport dev (output dsda_o, output dsda_oe, input scl, input sda);
endinterface

// file: rtl/rtcssp_dev.sv
// Purpose: Two-wire slave port and timekeeping core of the RTC
// Assumes: Line levels from outside, synchronised to pclk
// Notes: Oscillator ticks are enables divided from pclk
`timescale 1ns/1ps
`include "rtcssp_regs.svh"
// Behaviour
// - Answer only own address after START
// - Twenty locations in fixed sequence
// - Master starts only on idle bus
// - Data changes only while clock low
// - START and STOP by data edge, clock high
// - MSB first, ninth bit acknowledges
// - Hold data low through receive acknowledge
// - Release data after master withholds acknowledge
// - Pointer write, repeated START, then read
// - Pointer advances on acknowledge clock only
// - Freeze user time while pointer on time; code freezes only outside DEV_IDLE and DEV_IGN
// - Plain read starts at held pointer
// - First written byte loads pointer
// - Acknowledge address, pointer and data bytes
// - Timebase 32768 Hz, time in BCD
// - Time write clears fractional seconds
// - Century flag toggles only when enabled
// - Weekday low three bits, then date fields
// - Halt bit stops oscillator, clear restarts
// - Time write resets divider chain
module rtcssp_dev
  import rtcssp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  rtcssp_if.dev link,
  output logic osc_halted,
  output logic low_freq_output_enable,
  output logic century_flag
);
  rtcssp_dev_s_t r;
  rtcssp_dev_s_t n;

  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo,
                                         input logic [7:0] hi);
    if (v >= hi)
      return {1'b1, lo};
    if (v[3:0] >= 4'h9)
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
                   (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    case (mon)
      8'h02: month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction

  function automatic logic [4:0] ptr_next(input logic [4:0] p);
    return (p == `RTCSSP_LAST_REG) ? 5'h00 : p + 5'h01;
  endfunction

  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic start_c;
  logic stop_c;
  logic [8:0] c;
  logic [7:0] wd;

  assign scl = r.scl_s[1];
  assign sda = r.sda_s[1];
  assign rise = scl & ~r.scl_p;
  assign fall = ~scl & r.scl_p;
  assign start_c = scl & r.scl_p & r.sda_p & ~sda;
  assign stop_c = scl & r.scl_p & ~r.sda_p & sda;

  always_comb begin
    n = r;
    c = 9'h000;
    wd = 8'h00;
    n.scl_s = {r.scl_s[0], link.scl};
    n.sda_s = {r.sda_s[0], link.sda};
    n.scl_p = scl;
    n.sda_p = sda;

    // Timekeeping chain, stopped by the halt bit
    if (!r.tm[`RTCSSP_OFS_SEC][`RTCSSP_BIT_HALT]) begin
      n.odiv = r.odiv + 10'h001;
      if (r.odiv >= 10'(`RTCSSP_OSC_DIV - 1)) begin
        n.odiv = 10'h000;
        n.hdiv = r.hdiv + 9'h001;
        if (r.hdiv >= 9'(`RTCSSP_OSC_PER_HUND - 1)) begin
          n.hdiv = 9'h000;
          c = bcd_inc(r.tm[0], 8'h00, 8'h99);
          n.tm[0] = c[7:0];
          if (c[8]) begin
            c = bcd_inc({1'b0, r.tm[1][6:0]}, 8'h00, 8'h59);
            n.tm[1][6:0] = c[6:0];
          end
          if (c[8]) begin
            c = bcd_inc(r.tm[2], 8'h00, 8'h59);
            n.tm[2] = c[7:0];
          end
          if (c[8]) begin
            c = bcd_inc({2'b00, r.tm[3][5:0]}, 8'h00, 8'h23);
            n.tm[3][5:0] = c[5:0];
          end
          if (c[8]) begin
            n.tm[4][2:0] = (r.tm[4][2:0] >= 3'h7) ? 3'h1 : r.tm[4][2:0] + 3'h1;
            c = bcd_inc(r.tm[5], 8'h01, month_days(r.tm[6], r.tm[7]));
            n.tm[5] = c[7:0];
          end
          if (c[8]) begin
            c = bcd_inc(r.tm[6], 8'h01, 8'h12);
            n.tm[6] = c[7:0];
          end
          if (c[8]) begin
            c = bcd_inc(r.tm[7], 8'h00, 8'h99);
            n.tm[7] = c[7:0];
          end
          if (c[8] && r.tm[3][`RTCSSP_BIT_CTE])
            n.tm[3][`RTCSSP_BIT_CENT] = ~r.tm[3][`RTCSSP_BIT_CENT];
        end
      end
    end

    // Copy internal time into user registers unless frozen
    if (!r.frz) begin
      for (int i = 0; i < 8; i++)
        n.ur[i] = n.tm[i];
    end

    // Serial slave engine
    case (r.st)
      DEV_RX: begin
        if (rise) begin
          n.sh = {r.sh[6:0], sda};
          n.bcnt = r.bcnt + 3'h1;
          if (r.bcnt == 3'h7)
            n.got = 1'b1;
        end else if (fall && r.got) begin
          n.got = 1'b0;
          if (r.kind == 2'h0) begin
            if (r.sh[7:1] == `RTCSSP_SLAVE_ADDR >> 1) begin
              n.rw = r.sh[0];
              n.sda_oe = 1'b1;
              n.st = DEV_ACK;
            end else begin
              n.st = DEV_IGN;
            end
          end else if (r.kind == 2'h1) begin
            n.ptr = (r.sh < `RTCSSP_NREGS) ? r.sh[4:0] : 5'h00;
            n.sda_oe = 1'b1;
            n.st = DEV_ACK;
          end else begin
            wd = r.sh;
            if (r.ptr < `RTCSSP_NTIME) begin
              if (r.ptr == `RTCSSP_OFS_FRAC)
                wd = 8'h00;
              n.tm[r.ptr] = wd;
              n.ur[r.ptr] = wd;
              n.tm[`RTCSSP_OFS_FRAC] = 8'h00;
              n.ur[`RTCSSP_OFS_FRAC] = 8'h00;
              n.odiv = 10'h000;
              n.hdiv = 9'h000;
            end else if (r.ptr != `RTCSSP_OFS_FLAGS &&
                         !(r.ptr >= `RTCSSP_OFS_RSV_LO && r.ptr <= `RTCSSP_OFS_RSV_HI)) begin
              n.ur[r.ptr] = wd;
            end
            n.sda_oe = 1'b1;
            n.st = DEV_ACK;
          end
        end
      end
      DEV_ACK: begin
        if (fall) begin
          n.sda_oe = 1'b0;
          n.bcnt = 3'h0;
          n.st = DEV_RX;
          if (r.kind == 2'h0 && r.rw) begin
            n.sh = r.ur[r.ptr];
            n.sda_oe = ~r.ur[r.ptr][7];
            n.st = DEV_TX;
          end else if (r.kind == 2'h2) begin
            n.ptr = ptr_next(r.ptr);
          end else begin
            n.kind = r.kind + 2'h1;
          end
        end
      end
      DEV_TX: begin
        if (fall) begin
          if (r.bcnt == 3'h7) begin
            n.sda_oe = 1'b0;
            n.st = DEV_ACKR;
          end else begin
            n.sh = {r.sh[6:0], 1'b0};
            n.sda_oe = ~r.sh[6];
            n.bcnt = r.bcnt + 3'h1;
          end
        end
      end
      DEV_ACKR: begin
        if (rise) begin
          if (!sda) begin
            n.ptr = ptr_next(r.ptr);
            n.got = 1'b1;
          end else begin
            n.st = DEV_IGN;
          end
        end else if (fall && r.got) begin
          n.got = 1'b0;
          n.bcnt = 3'h0;
          n.sh = r.ur[r.ptr];
          n.sda_oe = ~r.ur[r.ptr][7];
          n.st = DEV_TX;
        end
      end
      DEV_IDLE, DEV_IGN: begin
        n.sda_oe = 1'b0;
      end
      default: begin
        n.st = DEV_IDLE;
        n.sda_oe = 1'b0;
      end
    endcase

    if (start_c) begin
      n.st = DEV_RX;
      n.kind = 2'h0;
      n.bcnt = 3'h0;
      n.got = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.st = DEV_IDLE;
      n.sda_oe = 1'b0;
    end

    n.frz = !(n.st == DEV_IDLE || n.st == DEV_IGN) && (n.ptr < `RTCSSP_NTIME);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.scl_s <= 2'b11;
      r.sda_s <= 2'b11;
      r.scl_p <= 1'b1;
      r.sda_p <= 1'b1;
      r.st <= DEV_IDLE;
      r.ur[`RTCSSP_OFS_LFO] <= `RTCSSP_RST_LFO;
      r.ur[`RTCSSP_OFS_WDAY] <= `RTCSSP_RST_MDAY;
      r.ur[`RTCSSP_OFS_MDAY] <= `RTCSSP_RST_MDAY;
      r.ur[`RTCSSP_OFS_MON] <= `RTCSSP_RST_MDAY;
      r.tm[`RTCSSP_OFS_MDAY] <= `RTCSSP_RST_MDAY;
      r.tm[`RTCSSP_OFS_MON] <= `RTCSSP_RST_MDAY;
      r.tm[`RTCSSP_OFS_WDAY] <= `RTCSSP_RST_MDAY;
    end else begin
      r <= n;
    end
  end

  assign link.dsda_o = 1'b0;
  assign link.dsda_oe = r.sda_oe;
  assign osc_halted = r.tm[`RTCSSP_OFS_SEC][`RTCSSP_BIT_HALT];
  assign low_freq_output_enable = r.ur[`RTCSSP_OFS_LFO][`RTCSSP_BIT_LFOE];
  assign century_flag = r.tm[`RTCSSP_OFS_HOUR][`RTCSSP_BIT_CENT];
endmodule

// file: rtl/rtcssp_host.sv
// Purpose: Two-wire bus master commanded over APB
// Assumes: Software sequences START, bytes and STOP
// Notes: One byte-level command at a time, no clock stretching
`timescale 1ns/1ps
`include "rtcssp_regs.svh"
module rtcssp_host
  import rtcssp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rtcssp_if.host link
);
  rtcssp_hst_s_t r;
  rtcssp_hst_s_t n;
  logic sda;
  logic tick;
  logic setup;
  logic acc;
  logic busy;

  assign sda = r.sda_s[1];
  assign tick = (r.qcnt == 6'(`RTCSSP_SCL_QTR - 1));
  assign setup = psel & ~penable;
  assign acc = psel & penable & r.pready;
  assign busy = (r.st != HST_IDLE);

  always_comb begin
    n = r;
    n.sda_s = {r.sda_s[0], link.sda};
    n.qcnt = (busy && !tick) ? r.qcnt + 6'h01 : 6'h00;

    // APB slave, one wait-free access phase
    n.pready = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        `RTCSSP_HOFS_CMD: n.prdata = 32'h0000_0000;
        `RTCSSP_HOFS_TXD: n.prdata = {24'h000000, r.txd};
        `RTCSSP_HOFS_RXD: n.prdata = {24'h000000, r.rxd};
        `RTCSSP_HOFS_STAT: n.prdata = {29'h0, sda, r.nack, busy};
        default: n.pslverr = 1'b1;
      endcase
    end
    if (acc && pwrite) begin
      if (paddr == `RTCSSP_HOFS_TXD)
        n.txd = pwdata[7:0];
      if (paddr == `RTCSSP_HOFS_CMD && !busy) begin
        n.q = 2'h0;
        n.bi = 4'h0;
        if (pwdata[`RTCSSP_CMD_START]) begin
          n.st = HST_START;
        end else if (pwdata[`RTCSSP_CMD_WRITE]) begin
          n.sh = {r.txd, 1'b1};
          n.st = HST_BIT;
        end else if (pwdata[`RTCSSP_CMD_READ]) begin
          n.sh = {8'hff, pwdata[`RTCSSP_CMD_NACK]};
          n.st = HST_BIT;
        end else if (pwdata[`RTCSSP_CMD_STOP]) begin
          n.st = HST_STOP;
        end
      end
    end

    // Line sequencer, four quarter periods per step
    if (busy && tick) begin
      n.q = r.q + 2'h1;
      case (r.st)
        HST_START: begin
          case (r.q)
            2'h0: n.sda_oe = 1'b0;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b1;
            default: begin
              n.scl_oe = 1'b1;
              n.st = HST_IDLE;
            end
          endcase
        end
        HST_STOP: begin
          case (r.q)
            2'h0: n.sda_oe = 1'b1;
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.sda_oe = 1'b0;
            default: n.st = HST_IDLE;
          endcase
        end
        HST_BIT: begin
          case (r.q)
            2'h0: n.sda_oe = ~r.sh[8];
            2'h1: n.scl_oe = 1'b0;
            2'h2: n.scl_oe = 1'b0;
            default: begin
              n.sh = {r.sh[7:0], sda};
              n.scl_oe = 1'b1;
              n.bi = r.bi + 4'h1;
              if (r.bi == 4'h8) begin
                n.rxd = r.sh[7:0];
                n.nack = sda;
                n.sda_oe = 1'b0;
                n.st = HST_IDLE;
              end
            end
          endcase
        end
        default: n.st = HST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.sda_s <= 2'b11;
      r.st <= HST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = r.scl_oe;
  assign link.hsda_o = 1'b0;
  assign link.hsda_oe = r.sda_oe;
endmodule

// file: verif/rtcssp_checker.sv
// Purpose: Concurrent checks on the two-wire link between controller and RTC port
// Assumes: Line levels resolved in rtcssp_if, pull-ups on both lines
// Notes: Instantiated beside the link in the bench
`timescale 1ns/1ps
module rtcssp_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic hsda_o,
  input wire logic hsda_oe,
  input wire logic dsda_o,
  input wire logic dsda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_reset_idle: assert property ($rose(presetn) |-> scl && sda && !dsda_oe)
    else $error("link not idle after reset");
  chk_start_idle: assert property ($fell(sda) && scl |-> $past(scl, 8) && $past(sda, 8))
    else $error("start without idle bus");
  chk_open_drain: assert property ((scl_oe |-> !scl_o) and (hsda_oe |-> !hsda_o))
    else $error("controller drives a line high");
  chk_dev_stable: assert property (scl && $past(scl) |-> $stable(dsda_oe))
    else $error("device data changed with clock high");
  chk_host_cond: assert property (scl && $changed(hsda_oe) |-> $past(scl, 30))
    else $error("controller data changed early in clock high");
  chk_scl_pulse: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_ack_low: assert property (dsda_oe && scl |-> !dsda_o && $past(dsda_oe, 3))
    else $error("device enable without low data");
  chk_ack_window: assert property ($rose(dsda_oe) |-> !scl [*3] ##[1:300] scl)
    else $error("device drive not in clock low phase");
  chk_stop_release: assert property ($rose(sda) && scl |-> !dsda_oe [*8])
    else $error("device drives data after stop");
endmodule

// file: verif/rtcssp_tb.sv
// Purpose: Self-checking bench of controller and RTC port joined by the link
// Assumes: Oscillator halted early so time registers hold still
// Notes: Random bytes from a fixed seed, corner cases by hand
`timescale 1ns/1ps
`include "rtcssp_regs.svh"
module rtcssp_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic osc_halted, lfo_en, cent;
  logic [7:0] paddr, sec, mnt, hr, x, y;
  logic [31:0] pwdata, prdata, r, stat;
  logic [7:0] ex [5];
  logic [8:0] mon_sh;
  int err_count, n_tests;
  int unsigned seed_v;

  rtcssp_if link();
  rtcssp_host u_rtcssp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  rtcssp_dev u_rtcssp_dev (.pclk(pclk), .presetn(presetn), .link(link),
    .osc_halted(osc_halted), .low_freq_output_enable(lfo_en), .century_flag(cent));
  rtcssp_checker u_rtcssp_checker (.pclk(pclk), .presetn(presetn), .scl_o(link.scl_o),
    .scl_oe(link.scl_oe), .hsda_o(link.hsda_o), .hsda_oe(link.hsda_oe), .dsda_o(link.dsda_o),
    .dsda_oe(link.dsda_oe), .scl(link.scl), .sda(link.sda));

  always #20 pclk = ~pclk;

  // Wire monitor: last nine bits seen on clock rising edges
  always @(posedge link.scl) begin
    mon_sh = {mon_sh[7:0], link.sda};
  end

  function automatic logic [7:0] bcd(input int v);
    bcd = {4'(v / 10), 4'(v % 10)};
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task op(input logic [31:0] c);
    apb(1'b1, `RTCSSP_HOFS_CMD, c, r);
    stat = 32'h1;
    while (stat[0] !== 1'b0) begin
      apb(1'b0, `RTCSSP_HOFS_STAT, 32'h0, stat);
    end
  endtask

  task sta;
    op(32'h1 << `RTCSSP_CMD_START);
  endtask

  task sto;
    op(32'h1 << `RTCSSP_CMD_STOP);
    chk(stat[2], 1'b1);
  endtask

  task wb(input logic [7:0] d, input logic nk);
    apb(1'b1, `RTCSSP_HOFS_TXD, {24'h0, d}, r);
    op(32'h1 << `RTCSSP_CMD_WRITE);
    chk(stat[1], nk);
  endtask

  task rb(input logic nk, input logic [7:0] e);
    op((32'h1 << `RTCSSP_CMD_READ) | (32'(nk) << `RTCSSP_CMD_NACK));
    apb(1'b0, `RTCSSP_HOFS_RXD, 32'h0, r);
    chk(r, {24'h0, e});
  endtask

  task rd_seq(input logic [7:0] p, input int n);
    sta;
    wb(`RTCSSP_SLAVE_ADDR, 1'b0);
    wb(p, 1'b0);
    sta;
    wb(`RTCSSP_SLAVE_ADDR | 8'h01, 1'b0);
    for (int i = 0; i < n; i++) begin
      rb(i == n - 1, ex[i]);
    end
    sto;
  endtask

  task end_sim;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge pclk);
    err_count++;
    end_sim;
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mon_sh = 9'h000;
    seed_v = $urandom(32'he918);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(lfo_en, 1'b1);
    chk(osc_halted, 1'b0);
    apb(1'b0, 8'h10, 32'h0, r);
    chk(perr, 1'b1);
    chk(r, 32'h0);
    x = 8'($urandom);
    apb(1'b1, `RTCSSP_HOFS_TXD, {24'h0, x}, r);
    apb(1'b0, `RTCSSP_HOFS_TXD, 32'h0, r);
    chk(r, {24'h0, x});
    // Current-address read from the reset pointer
    sta;
    wb(`RTCSSP_SLAVE_ADDR | 8'h01, 1'b0);
    chk(mon_sh, {`RTCSSP_SLAVE_ADDR | 8'h01, 1'b0});
    rb(1'b1, 8'h00);
    sto;
    // Time write with halt and century bits set
    sec = 8'h80 | bcd($urandom % 60);
    mnt = bcd($urandom % 60);
    hr = 8'hc0 | bcd($urandom % 24);
    sta;
    wb(`RTCSSP_SLAVE_ADDR, 1'b0);
    wb(8'h01, 1'b0);
    wb(sec, 1'b0);
    wb(mnt, 1'b0);
    wb(hr, 1'b0);
    sto;
    chk(osc_halted, 1'b1);
    chk(cent, 1'b1);
    ex = '{8'h00, sec, mnt, hr, 8'h01};
    rd_seq(8'h00, 5);
    // Foreign address is left unanswered
    sta;
    x = {3'b101, 4'($urandom), 1'b0};
    wb(x, 1'b1);
    chk(mon_sh[0], 1'b1);
    wb(8'($urandom), 1'b1);
    sto;
    // Write across the top location and wrap to zero
    x = 8'($urandom);
    y = {4'($urandom), 4'h0};
    sta;
    wb(`RTCSSP_SLAVE_ADDR, 1'b0);
    wb(8'h12, 1'b0);
    wb(x, 1'b0);
    wb(y, 1'b0);
    wb(8'($urandom) | 8'h01, 1'b0);
    sto;
    ex = '{8'h00, y, 8'h00, sec, 8'h00};
    rd_seq(8'h12, 4);
    chk(link.sda, 1'b1);
    end_sim;
  end
endmodule
